// >>> logic/irft_readout_timing.sv
`timescale 1ns/1ps

// Functional notes
// - Bayer rows alternate blue/green and green/red
// - columns ascend 0..1615, descend when inverted
// - default readout starts at lower-left corner
// - inversion supported; raw output keeps physical phase
// - frame rows equal blank plus valid plus 8 for short exposure
// - blank total is gap plus both margins
// - each margin comes from its own setting
// - valid rows equal window height minus 8
// - short exposure: gap is blank minus margins
// - long exposure: gap stretches to exposure term
// - row period is pad+lag+width/2+4
// - pad twelve bits, lag ten split bits
// - vsync inactive during gap, active low
module irft_readout_timing (
    // clocks and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        pix_clk,
    // configuration, clk_sys domain
    input  wire logic        col_invert,
    input  wire logic        row_invert,
    input  wire logic        raw_mode,
    input  wire logic [12:0] vertical_blank_total,
    input  wire logic [7:0]  pre_frame_margin,
    input  wire logic [7:0]  post_frame_margin,
    input  wire logic [10:0] win_height,
    input  wire logic [10:0] win_width,
    input  wire logic [11:0] horizontal_pad_pixels,
    input  wire logic [1:0]  sample_hold_lag_hi,
    input  wire logic [7:0]  sample_hold_lag_lo,
    input  wire logic [12:0] exposure_rows,
    // status, clk_sys domain
    output logic             frame_active,
    // pixel array access, pix_clk domain
    output logic             arr_rd,
    output logic [10:0]      arr_row,
    output logic [10:0]      arr_col_a,
    output logic [10:0]      arr_col_b,
    input  wire logic [9:0]  arr_data_a,
    input  wire logic [9:0]  arr_data_b,
    // parallel output, pix_clk domain
    output logic             vsync_n,
    output logic             hsync,
    output logic [9:0]       pix_data_a,
    output logic [9:0]       pix_data_b,
    output logic [1:0]       pix_bayer
);

    irft_pkg::irft_cfg_t cfg_in;
    irft_pkg::irft_cfg_t snap;
    irft_pkg::irft_cfg_t pend;
    irft_pkg::irft_cfg_t act;
    logic                link_rst;
    logic                req_tgl;
    logic                req_sync;
    logic                req_seen;
    logic                ack_sync;
    logic                cfg_boot;
    logic                boot_apply;

    assign cfg_in = '{
        col_invert: col_invert, row_invert: row_invert, raw_mode: raw_mode,
        vb_total: vertical_blank_total, pre_margin: pre_frame_margin, post_margin: post_frame_margin,
        win_height: win_height, win_width: win_width, hpad: horizontal_pad_pixels,
        sh_lag: {sample_hold_lag_hi, sample_hold_lag_lo}, exposure: exposure_rows};

    irft_sync2 u_rst_sync (
        .clk (pix_clk),
        .d   (rst),
        .q   (link_rst)
    );

    // snapshot is held still until the link side echoes the toggle, so the
    // link side may read the whole word once it sees the request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            req_tgl <= 1'b0;
            snap    <= irft_pkg::CFG_RESET;
        end else if (req_tgl == ack_sync) begin
            req_tgl <= ~req_tgl;
            snap    <= cfg_in;
        end
    end

    irft_sync2 u_req_sync (
        .clk (pix_clk),
        .d   (req_tgl),
        .q   (req_sync)
    );

    // the first word after reset starts a frame at once, so nothing waits
    // through a whole frame of the default full-array timing
    always_ff @(posedge pix_clk) begin
        if (link_rst) begin
            req_seen   <= 1'b0;
            pend       <= irft_pkg::CFG_RESET;
            cfg_boot   <= 1'b1;
            boot_apply <= 1'b0;
        end else begin
            boot_apply <= cfg_boot && (req_sync != req_seen);
            if (req_sync != req_seen) begin
                req_seen <= req_sync;
                pend     <= snap;
                cfg_boot <= 1'b0;
            end
        end
    end

    irft_sync2 u_ack_sync (
        .clk (clk_sys),
        .d   (req_seen),
        .q   (ack_sync)
    );

    // ---------------- frame and row timing ----------------
    irft_pkg::irft_vstate_t vstate;
    irft_pkg::irft_vstate_t next_vstate;
    irft_pkg::irft_vstate_t first_vstate;
    logic [13:0] pix_cnt;
    logic [13:0] row_cnt;
    logic [13:0] gap_len;
    logic [13:0] next_gap;
    logic [13:0] row_len;
    logic [13:0] phase_len;
    logic        row_end;
    logic        phase_done;
    logic        frame_end;
    logic        frame_load;

    assign row_len    = irft_pkg::row_period(act);
    assign row_end    = (pix_cnt == 14'(row_len - 14'h0001));
    assign phase_done = row_end && (row_cnt == 14'(phase_len - 14'h0001));
    assign frame_end  = phase_done && ((vstate == irft_pkg::ST_POST)
                        || (vstate == irft_pkg::ST_WIN && act.post_margin == 8'h00));
    assign next_gap   = irft_pkg::gap_rows(pend);
    assign frame_load = frame_end || boot_apply;

    always_comb begin
        case (vstate)
            irft_pkg::ST_GAP:  phase_len = gap_len;
            irft_pkg::ST_PRE:  phase_len = 14'(act.pre_margin);
            irft_pkg::ST_WIN:  phase_len = 14'(act.win_height);
            irft_pkg::ST_POST: phase_len = 14'(act.post_margin);
            default:           phase_len = gap_len;
        endcase
    end

    // empty phases are skipped so the frame length stays exact
    always_comb begin
        case (vstate)
            irft_pkg::ST_GAP:  next_vstate = (act.pre_margin != 8'h00) ? irft_pkg::ST_PRE : irft_pkg::ST_WIN;
            irft_pkg::ST_PRE:  next_vstate = irft_pkg::ST_WIN;
            irft_pkg::ST_WIN:  next_vstate = irft_pkg::ST_POST;
            irft_pkg::ST_POST: next_vstate = irft_pkg::ST_GAP;
            default:           next_vstate = irft_pkg::ST_GAP;
        endcase
        if (next_gap != 14'h0000)
            first_vstate = irft_pkg::ST_GAP;
        else if (pend.pre_margin != 8'h00)
            first_vstate = irft_pkg::ST_PRE;
        else
            first_vstate = irft_pkg::ST_WIN;
    end

    always_ff @(posedge pix_clk) begin
        if (link_rst || row_end || boot_apply)
            pix_cnt <= 14'h0000;
        else
            pix_cnt <= 14'(pix_cnt + 14'h0001);
    end

    // frame = gap + pre + height + post = blank total + valid rows + 8 for short exposure
    always_ff @(posedge pix_clk) begin
        if (link_rst) begin
            vstate  <= irft_pkg::ST_GAP;
            row_cnt <= 14'h0000;
            act     <= irft_pkg::CFG_RESET;
            gap_len <= irft_pkg::gap_rows(irft_pkg::CFG_RESET);
        end else if (frame_load) begin
            row_cnt <= 14'h0000;
            act     <= pend;
            gap_len <= next_gap;
            vstate  <= first_vstate;
        end else if (phase_done) begin
            row_cnt <= 14'h0000;
            vstate  <= next_vstate;
        end else if (row_end) begin
            row_cnt <= 14'(row_cnt + 14'h0001);
        end
    end

    // ---------------- readout addressing ----------------
    logic [13:0] lead;
    logic [13:0] span;
    logic        row_valid;
    logic        pair_valid;
    logic [10:0] lcol;
    logic [10:0] lrow;
    logic [10:0] pcol;
    logic [10:0] prow;

    assign lead       = 14'(act.hpad) + 14'(act.sh_lag);
    assign span       = 14'(pix_cnt - lead);
    assign row_valid  = (vstate == irft_pkg::ST_WIN) && (row_cnt >= irft_pkg::EDGE_ROWS)
                        && (row_cnt < 14'(14'(act.win_height) - irft_pkg::EDGE_ROWS));
    assign pair_valid = (pix_cnt >= lead) && (span >= irft_pkg::EDGE_PAIRS)
                        && (span < 14'(14'(act.win_width[10:1]) - irft_pkg::EDGE_PAIRS));
    assign lcol       = {span[9:0], 1'b0};
    assign lrow       = row_cnt[10:0];
    assign pcol       = act.col_invert ? 11'(irft_pkg::ARRAY_LAST_COL - lcol) : lcol;
    assign prow       = act.row_invert ? lrow : 11'(irft_pkg::ARRAY_LAST_ROW - lrow);

    logic        vs1;
    logic        vs2;
    logic        rd2;
    irft_pkg::irft_bayer_t bayer1;
    irft_pkg::irft_bayer_t bayer2;

    always_ff @(posedge pix_clk) begin
        if (link_rst) begin
            arr_rd    <= 1'b0;
            arr_row   <= 11'h000;
            arr_col_a <= 11'h000;
            arr_col_b <= 11'h000;
            bayer1    <= 2'h0;
            vs1       <= 1'b0;
        end else begin
            arr_rd    <= row_valid && pair_valid;
            arr_row   <= prow;
            arr_col_a <= pcol;
            arr_col_b <= act.col_invert ? 11'(pcol - 11'h001) : 11'(pcol + 11'h001);
            // processed formats report the logical phase, raw the physical one
            bayer1    <= act.raw_mode ? irft_pkg::bayer_of(prow[0], pcol[0])
                                      : irft_pkg::bayer_of(lrow[0], lcol[0]);
            vs1       <= (vstate != irft_pkg::ST_GAP);
        end
    end

    // array answers one cycle after the address, hence the middle stage
    always_ff @(posedge pix_clk) begin
        if (link_rst) begin
            rd2    <= 1'b0;
            vs2    <= 1'b0;
            bayer2 <= 2'h0;
        end else begin
            rd2    <= arr_rd;
            vs2    <= vs1;
            bayer2 <= bayer1;
        end
    end

    always_ff @(posedge pix_clk) begin
        if (link_rst) begin
            vsync_n    <= 1'b1;
            hsync      <= 1'b0;
            pix_data_a <= 10'h000;
            pix_data_b <= 10'h000;
            pix_bayer  <= 2'h0;
        end else begin
            vsync_n    <= ~vs2;
            hsync      <= rd2;
            pix_data_a <= rd2 ? arr_data_a : 10'h000;
            pix_data_b <= rd2 ? arr_data_b : 10'h000;
            pix_bayer  <= rd2 ? bayer2 : 2'h0;
        end
    end

    irft_sync2 u_frame_sync (
        .clk (clk_sys),
        .d   (vs1),
        .q   (frame_active)
    );

    // ---------------- checks ----------------
    logic [13:0] per_cnt;
    logic [13:0] per_len;
    logic        per_seen;
    logic [13:0] frm_rows;
    logic [13:0] frm_exp;
    logic        frm_seen;
    logic [13:0] out_rows;
    logic [13:0] out_exp;

    always_ff @(posedge pix_clk) begin
        if (link_rst) begin
            per_cnt  <= 14'h0000;
            per_len  <= 14'h0000;
            per_seen <= 1'b0;
            frm_rows <= 14'h0000;
            frm_exp  <= 14'h0000;
            frm_seen <= 1'b0;
        end else begin
            per_cnt  <= row_end ? 14'h0000 : 14'(per_cnt + 14'h0001);
            per_len  <= row_len;
            per_seen <= per_seen | row_end;
            if (frame_end) begin
                frm_rows <= 14'h0000;
                frm_exp  <= 14'(14'(pend.vb_total) + 14'(pend.win_height) - irft_pkg::WIN_ROW_OVERHD
                           + irft_pkg::WIN_ROW_OVERHD);
                frm_seen <= 1'b1;
            end else if (row_end) begin
                frm_rows <= 14'(frm_rows + 14'h0001);
            end
        end
    end

    always_ff @(posedge pix_clk) begin
        if (link_rst) begin
            out_rows <= 14'h0000;
            out_exp  <= 14'h0000;
        end else if (vs2 && vsync_n) begin
            out_rows <= 14'h0000;
            out_exp  <= 14'(14'(act.win_height) - irft_pkg::WIN_ROW_OVERHD);
        end else if (rd2 && !hsync) begin
            out_rows <= 14'(out_rows + 14'h0001);
        end
    end

    chk_row_len_exact: assert property (@(posedge pix_clk) disable iff (link_rst)
        (row_end && per_seen && $past(row_end) == 1'b0) |-> (per_cnt == 14'(per_len - 14'h0001)))
        else $error("row period differs from pad plus lag plus half width plus four");

    chk_frame_rows: assert property (@(posedge pix_clk) disable iff (link_rst)
        (frame_end && frm_seen && gap_len != 14'h0000) |-> (14'(frm_rows + 14'h0001) == frm_exp
         || 14'(act.exposure) > 14'(14'(act.win_height) + 14'(act.vb_total))))
        else $error("frame row count is not blank plus valid plus eight");

    chk_gap_select: assert property (@(posedge pix_clk) disable iff (link_rst)
        (frame_end && 14'(pend.pre_margin) + 14'(pend.post_margin) <= 14'(pend.vb_total)
         && 14'(pend.exposure) <= 14'(14'(pend.win_height) + 14'(pend.vb_total)))
        |=> gap_len == 14'(14'(act.vb_total) - 14'(act.pre_margin) - 14'(act.post_margin)))
        else $error("sync idle gap wrong for short exposure");

    chk_valid_rows: assert property (@(posedge pix_clk) disable iff (link_rst)
        (!vs2 && !vsync_n) |-> (out_rows == out_exp))
        else $error("valid row count is not window height minus eight");

    chk_col_ascend: assert property (@(posedge pix_clk) disable iff (link_rst)
        (arr_rd && $past(arr_rd) && !act.col_invert && $stable(act))
        |-> (arr_col_a == 11'($past(arr_col_a) + 11'h002) && arr_col_b == 11'(arr_col_a + 11'h001)))
        else $error("columns not read in ascending order");

    chk_col_descend: assert property (@(posedge pix_clk) disable iff (link_rst)
        (arr_rd && $past(arr_rd) && act.col_invert && $stable(act))
        |-> (arr_col_a == 11'($past(arr_col_a) - 11'h002) && arr_col_b == 11'(arr_col_a - 11'h001)))
        else $error("columns not read in descending order");

    chk_gap_vsync: assert property (@(posedge pix_clk) disable iff (link_rst)
        (vstate == irft_pkg::ST_GAP) |-> ##3 vsync_n)
        else $error("vsync active during sync idle gap");

    chk_hsync_data: assert property (@(posedge pix_clk) disable iff (link_rst)
        hsync |-> (!vsync_n && $past(arr_rd, 2) && pix_data_a == $past(arr_data_a)))
        else $error("hsync without valid pixel data");

    chk_cfg_frame: assert property (@(posedge pix_clk) disable iff (link_rst)
        !frame_load |=> $stable(act))
        else $error("timing settings changed inside a frame");

    chk_raw_phase: assert property (@(posedge pix_clk) disable iff (link_rst)
        (arr_rd && act.raw_mode && $stable(act)) |-> ##2 (pix_bayer == {$past(arr_row[0], 2), $past(arr_col_a[0], 2)}))
        else $error("raw bayer phase does not follow the physical pixel");

endmodule // irft_readout_timing

// >>> inc/irft_pkg.sv
package irft_pkg;

    // array geometry
    localparam logic [10:0] ARRAY_LAST_COL = 11'h64f;
    localparam logic [10:0] ARRAY_LAST_ROW = 11'h4cf;

    // row and frame overheads
    localparam logic [13:0] ROW_TAIL_CYCLES = 14'h0004;
    localparam logic [13:0] EDGE_PAIRS      = 14'h0002;
    localparam logic [13:0] EDGE_ROWS       = 14'h0004;
    localparam logic [13:0] WIN_ROW_OVERHD  = 14'h0008;

    typedef struct packed {
        logic        col_invert;
        logic        row_invert;
        logic        raw_mode;
        logic [12:0] vb_total;
        logic [7:0]  pre_margin;
        logic [7:0]  post_margin;
        logic [10:0] win_height;
        logic [10:0] win_width;
        logic [11:0] hpad;
        logic [9:0]  sh_lag;
        logic [12:0] exposure;
    } irft_cfg_t;

    // values the timing runs with until the first transfer lands
    localparam irft_cfg_t CFG_RESET = '{
        col_invert: 1'b0, row_invert: 1'b0, raw_mode: 1'b0,
        vb_total: 13'h000c, pre_margin: 8'h02, post_margin: 8'h02,
        win_height: 11'h4d0, win_width: 11'h650, hpad: 12'h0aa,
        sh_lag: 10'h000, exposure: 13'h0000};

    typedef enum logic [1:0] {
        ST_GAP  = 2'b00,
        ST_PRE  = 2'b01,
        ST_WIN  = 2'b11,
        ST_POST = 2'b10
    } irft_vstate_t;

    // {row odd, col odd}: 0 blue, 1 green on blue row, 2 green on red row, 3 red
    typedef logic [1:0] irft_bayer_t;

    function automatic irft_bayer_t bayer_of(input logic row_odd, input logic col_odd);
        return {row_odd, col_odd};
    endfunction

    function automatic logic [13:0] sat_sub(input logic [13:0] a, input logic [13:0] b);
        return (a > b) ? 14'(a - b) : 14'h0000;
    endfunction

    function automatic logic [13:0] gap_rows(input irft_cfg_t c);
        logic [13:0] margins;
        logic [13:0] limit;
        margins = 14'(c.pre_margin) + 14'(c.post_margin);
        limit   = 14'(c.win_height) + 14'(c.vb_total);
        if (14'(c.exposure) > limit)
            return sat_sub(sat_sub(14'(c.exposure), 14'(c.win_height)), margins);
        return sat_sub(14'(c.vb_total), margins);
    endfunction

    function automatic logic [13:0] row_period(input irft_cfg_t c);
        return 14'(c.hpad) + 14'(c.sh_lag) + 14'(c.win_width[10:1]) + ROW_TAIL_CYCLES;
    endfunction

endpackage

// >>> logic/irft_sync2.sv
`timescale 1ns/1ps

module irft_sync2 (
    // destination clock
    input  wire logic clk,
    // level from the other domain
    input  wire logic d,
    // synchronised level
    output logic      q
);

    logic meta;

    // meta is seen by q alone
    always_ff @(posedge clk) begin
        meta <= d;
        q    <= meta;
    end

endmodule // irft_sync2

// >>> verif/irft_array_model.sv
`timescale 1ns/1ps

module irft_array_model (
    // pixel clock
    input  wire logic        pix_clk,
    // address from the block
    input  wire logic        arr_rd,
    input  wire logic [10:0] arr_col_a,
    input  wire logic [10:0] arr_col_b,
    // sampled pixel pair
    output logic [9:0]       arr_data_a,
    output logic [9:0]       arr_data_b
);
    // data is good only in the cycle after a read; between reads it churns so a late sample shows
    always @(posedge pix_clk) begin
        if (arr_rd) begin
            arr_data_a <= arr_col_a[9:0] ^ 10'h2a5;
            arr_data_b <= arr_col_b[9:0] ^ 10'h2a5;
        end else begin
            arr_data_a <= ~arr_data_a;
            arr_data_b <= ~arr_data_b;
        end
    end
endmodule // irft_array_model

// >>> verif/irft_testbench.sv
`timescale 1ns/1ps

module testbench;
    logic        clk_sys, rst, pix_clk;
    logic        col_invert, row_invert, raw_mode;
    logic [12:0] vertical_blank_total, exposure_rows;
    logic [7:0]  pre_frame_margin, post_frame_margin, sample_hold_lag_lo;
    logic [10:0] win_height, win_width, arr_row, arr_col_a, arr_col_b;
    logic [11:0] horizontal_pad_pixels;
    logic [1:0]  sample_hold_lag_hi, pix_bayer;
    logic        frame_active, arr_rd, vsync_n, hsync;
    logic [9:0]  arr_data_a, arr_data_b, pix_data_a, pix_data_b;
    int          error_cnt = 0;
    int          n_tests = 0;

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        pix_clk = 1'b0;
        #7;
        forever #15 pix_clk = ~pix_clk;
    end

    irft_readout_timing dut (.clk_sys(clk_sys), .rst(rst), .pix_clk(pix_clk), .col_invert(col_invert),
        .row_invert(row_invert), .raw_mode(raw_mode), .vertical_blank_total(vertical_blank_total),
        .pre_frame_margin(pre_frame_margin), .post_frame_margin(post_frame_margin),
        .win_height(win_height), .win_width(win_width), .horizontal_pad_pixels(horizontal_pad_pixels),
        .sample_hold_lag_hi(sample_hold_lag_hi), .sample_hold_lag_lo(sample_hold_lag_lo),
        .exposure_rows(exposure_rows), .frame_active(frame_active), .arr_rd(arr_rd), .arr_row(arr_row),
        .arr_col_a(arr_col_a), .arr_col_b(arr_col_b), .arr_data_a(arr_data_a), .arr_data_b(arr_data_b),
        .vsync_n(vsync_n), .hsync(hsync), .pix_data_a(pix_data_a), .pix_data_b(pix_data_b),
        .pix_bayer(pix_bayer));

    irft_array_model array (.pix_clk(pix_clk), .arr_rd(arr_rd), .arr_col_a(arr_col_a),
        .arr_col_b(arr_col_b), .arr_data_a(arr_data_a), .arr_data_b(arr_data_b));

    function automatic logic [9:0] pat(input logic [10:0] c);
        return c[9:0] ^ 10'h2a5;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic stop_test;
        if (error_cnt == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // window kept at 16 rows by 24 columns (16 output columns plus 8) so frames stay short
    task automatic put(input logic [12:0] vb, ex, input logic [7:0] pre, post,
                       input logic [11:0] pad, input logic [9:0] lag, input logic [2:0] flg);
        vertical_blank_total = vb;
        exposure_rows = ex;
        pre_frame_margin = pre;
        post_frame_margin = post;
        win_height = 11'h010;
        win_width = 11'h018;
        horizontal_pad_pixels = pad;
        {sample_hold_lag_hi, sample_hold_lag_lo} = lag;
        {col_invert, row_invert, raw_mode} = flg;
    endtask

    // measures one frame from a vsync fall to the next; gap or tot below zero skips that figure
    task automatic frame(input int tot, lo, gap, rowp, input logic ci, ri, raw);
        int          cyc, vhi, nrow, k, rise;
        logic        vs_d, hs_d;
        logic [10:0] col, prow;
        cyc = 0;
        vhi = 0;
        nrow = 0;
        k = 0;
        rise = -1;
        vs_d = 1'b0;
        hs_d = 1'b0;
        prow = 11'h000;
        @(negedge vsync_n);
        while (cyc < 20000) begin
            @(posedge pix_clk);
            #1;
            cyc++;
            if (vs_d && !vsync_n)
                break;
            vs_d = vsync_n;
            vhi += vsync_n;
            if (vsync_n && vhi == 40) chk("frame_active in gap", 0, frame_active);
            if (hsync) begin
                if (!hs_d) begin
                    if (rise >= 0) chk("row period", rowp, cyc - rise);
                    if (nrow > 0) chk("row step", ri ? prow + 11'h001 : prow - 11'h001, arr_row);
                    else chk("first row half", ri, arr_row < 11'h268);
                    chk("frame_active in window", 1, frame_active);
                    rise = cyc;
                    nrow++;
                    k = 0;
                    prow = arr_row;
                end
                col = ci ? 11'h64b - 11'(2 * k) : 11'(4 + 2 * k);
                chk("pix_data_a", pat(col), pix_data_a);
                chk("pix_data_b", pat(ci ? col - 11'h001 : col + 11'h001), pix_data_b);
                chk("pix_bayer", raw ? {arr_row[0], col[0]} : {~nrow[0], 1'b0}, pix_bayer);
                chk("vsync_n with hsync", 0, vsync_n);
                k++;
            end else begin
                if (hs_d) chk("pairs per row", 8, k);
                chk("idle data", 0, {pix_data_a, pix_data_b, pix_bayer});
            end
            hs_d = hsync;
        end
        if (tot >= 0) chk("frame period", tot * rowp, cyc);
        if (gap >= 0) chk("gap span", gap * rowp, vhi);
        chk("active span", lo * rowp, cyc - vhi);
        chk("valid rows", 8, nrow);
    endtask

    // exposure equal to height plus blank is still the short case
    task automatic t_short;
        @(negedge vsync_n);
        frame(22, 19, 3, 24, 1'b0, 1'b0, 1'b0);
    endtask

    task automatic t_invert;
        @(posedge clk_sys);
        #2;
        put(13'h0005, 13'h0000, 8'h03, 8'h00, 12'h006, 10'h101, 3'b111);
        frame(21, 19, 2, 279, 1'b1, 1'b1, 1'b1);
    endtask

    task automatic t_long_exposure;
        @(posedge clk_sys);
        #2;
        put(13'h0006, 13'h0028, 8'h00, 8'h01, 12'h006, 10'h002, 3'b100);
        frame(40, 17, 23, 24, 1'b1, 1'b0, 1'b0);
    endtask

    // the change lands inside the window, so the running frame must keep its old row period
    task automatic t_midframe;
        fork
            frame(-1, 17, -1, 24, 1'b1, 1'b0, 1'b0);
            begin
                @(negedge vsync_n);
                repeat (60) @(posedge clk_sys);
                #2;
                put(13'h0006, 13'h0016, 8'h02, 8'h01, 12'h00a, 10'h002, 3'b000);
            end
        join
        frame(22, 19, 3, 28, 1'b0, 1'b0, 1'b0);
    endtask

    initial begin
        rst = 1'b1;
        put(13'h0006, 13'h0016, 8'h02, 8'h01, 12'h006, 10'h002, 3'b000);
        repeat (4) @(posedge clk_sys);
        #2;
        rst = 1'b0;
        t_short();
        t_invert();
        t_long_exposure();
        t_midframe();
        stop_test();
    end

    // all scenarios together need about 17,500 pixel clocks; the limit allows roughly twice that
    initial begin
        #1200us;
        error_cnt++;
        stop_test();
    end
endmodule // testbench
